// ===== tbl_access_defs.svh
// register offsets, field positions and reset values for the static / reserved multicast table access block
// assumes byte addressing on the switch register port, one 32-bit word per register
`ifndef TBL_ACCESS_DEFS_SVH
`define TBL_ACCESS_DEFS_SVH

`define REG_ADDR_W        16
`define OFF_TBL_CTRL      16'h041C
`define OFF_ENTRY_1       16'h0420
`define OFF_ENTRY_2       16'h0424
`define OFF_ENTRY_3       16'h0428
`define OFF_ENTRY_4       16'h042C

`define CTRL_IDX_HI       21
`define CTRL_IDX_LO       16
`define CTRL_SIDX_HI      19
`define CTRL_GO_BIT       7
`define CTRL_RSV_HI       6
`define CTRL_RSV_LO       2
`define CTRL_SEL_BIT      1
`define CTRL_ACT_BIT      0

`define CTRL_IDX_RST      6'h00
`define CTRL_RSV_RST      5'h00
`define ENTRY_RST         32'h0000_0000
`define RDATA_UNMAPPED    32'h0000_0000

`define ACT_READ          1'b1
`define SEL_RMC           1'b1

`define STATIC_DEPTH      16
`define RMC_DEPTH         64
`define ENTRY_WORDS       4
`define RMC_WORD          1

`endif

// ===== tbl_access_pkg.sv
// types shared by the table access register block and its table store
// constants live in tbl_access_defs.svh
package tbl_access_pkg;

    // one table access as handed to the store
    typedef struct packed {
        logic       rmc_sel;
        logic       do_read;
        logic [5:0] index;
    } tbl_cmd_t;

    // the four shared entry words, word 0 is entry register 1
    typedef logic [3:0][31:0] entry_words_t;

    // access sequencer, gray along idle -> issue -> wait; the wait -> idle step flips both bits
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT  = 2'b11
    } acc_state_t;

endpackage

// ===== table_store.sv
// flip-flop storage for the static address table and the reserved multicast table
// assumes one command pulse at a time from the access sequencer in the same clock domain
`timescale 1ns/1ps
`include "tbl_access_defs.svh"

module table_store #(
    parameter int STATIC_DEPTH = `STATIC_DEPTH,
    parameter int RMC_DEPTH    = `RMC_DEPTH
) (
    input  wire logic                         sys_clk,
    input  wire logic                         resetn,
    input  wire logic                         cmd_valid,
    input  wire tbl_access_pkg::tbl_cmd_t     cmd,
    input  wire tbl_access_pkg::entry_words_t wr_words,
    output tbl_access_pkg::entry_words_t      rd_words,
    output logic                              rd_done
);
    import tbl_access_pkg::*;

    logic [127:0] static_mem [STATIC_DEPTH];
    logic [31:0]  rmc_mem    [RMC_DEPTH];
    logic [3:0]   static_idx;
    logic [5:0]   rmc_idx;
    logic         wr_cmd;

    // static table sees only the low four index bits, upper two ignored
    assign static_idx = cmd.index[`CTRL_SIDX_HI-`CTRL_IDX_LO:0];
    assign rmc_idx    = cmd.index;
    assign wr_cmd     = cmd_valid && (cmd.do_read != `ACT_READ);

    // one write-enabled row per entry; row select decoded from the index
    genvar g;
    generate
        for (g = 0; g < STATIC_DEPTH; g++)
        begin : g_static
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                    static_mem[g] <= '0;
                else if (wr_cmd && cmd.rmc_sel != `SEL_RMC && static_idx == 4'(g))
                    static_mem[g] <= wr_words;
            end
        end
        for (g = 0; g < RMC_DEPTH; g++)
        begin : g_rmc
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                    rmc_mem[g] <= '0;
                else if (wr_cmd && cmd.rmc_sel == `SEL_RMC && rmc_idx == 6'(g))
                    rmc_mem[g] <= wr_words[`RMC_WORD];
            end
        end
    endgenerate

    // read data captured on the command edge; multicast fills only word 2
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rd_words <= '0;
        else if (cmd_valid && cmd.do_read == `ACT_READ)
        begin
            if (cmd.rmc_sel == `SEL_RMC)
                rd_words <= {32'h0000_0000, 32'h0000_0000, rmc_mem[rmc_idx], 32'h0000_0000};
            else
                rd_words <= static_mem[static_idx];
        end
    end

    // completion pulse one cycle after the command, for reads and writes alike
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rd_done <= 1'b0;
        else
            rd_done <= cmd_valid;
    end

endmodule

// ===== static_mcast_table_access.sv
// register block for static address and reserved multicast table access
// assumes the switch register port: byte address, one-cycle read/write strobes, sys_clk domain
//
// Contract
// - writing go starts access; hardware clears when done
// - selector one: multicast table; zero: static table
// - action one reads entry; zero writes entry
// - multicast table indexed by all six index bits
// - static table uses low four index bits only
// - static entries move through all four words
// - multicast entries move through word two only
// - entry word layout depends on selected table
`timescale 1ns/1ps
`include "tbl_access_defs.svh"

module static_mcast_table_access #(
    parameter int STATIC_DEPTH = `STATIC_DEPTH,
    parameter int RMC_DEPTH    = `RMC_DEPTH
) (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire logic [`REG_ADDR_W-1:0] reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [31:0]            reg_wdata,
    output logic [31:0]                 reg_rdata,
    output logic                        reg_rvalid,
    output logic                        access_busy
);
    import tbl_access_pkg::*;

    logic [5:0]   index_r;
    logic         sel_r;
    logic         act_r;
    logic [4:0]   rsv_r;
    logic         access_go_done_r;
    acc_state_t   state_r;
    acc_state_t   state_nxt;
    entry_words_t entry_r;
    entry_words_t store_rd;
    logic         store_done;
    logic         cmd_valid;
    tbl_cmd_t     cmd;
    logic         wr_ctrl;
    logic         start;
    logic [31:0]  ctrl_view;
    logic [31:0]  rdata_nxt;

    // control writes are refused while an access runs so the command stays stable
    assign wr_ctrl = reg_wr && reg_addr == `OFF_TBL_CTRL && state_r == ST_IDLE;
    assign start   = wr_ctrl && reg_wdata[`CTRL_GO_BIT];

    // index, selector, action and the writable reserved bits
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            index_r <= `CTRL_IDX_RST;
            sel_r   <= 1'b0;
            act_r   <= 1'b0;
            rsv_r   <= `CTRL_RSV_RST;
        end
        else if (wr_ctrl)
        begin
            index_r <= reg_wdata[`CTRL_IDX_HI:`CTRL_IDX_LO];
            sel_r   <= reg_wdata[`CTRL_SEL_BIT];
            act_r   <= reg_wdata[`CTRL_ACT_BIT];
            rsv_r   <= reg_wdata[`CTRL_RSV_HI:`CTRL_RSV_LO];
        end
    end

    // go/done flag: set by software, self-cleared when the store reports completion
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            access_go_done_r <= 1'b0;
        else if (start)
            access_go_done_r <= 1'b1;
        else if (state_r == ST_WAIT && store_done)
            access_go_done_r <= 1'b0;
    end

    // sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (start)
                    state_nxt = ST_ISSUE;
            end
            ST_ISSUE:
            begin
                state_nxt = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (store_done)
                    state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // command built from the latched control fields
    assign cmd_valid   = state_r == ST_ISSUE;
    assign cmd.rmc_sel = sel_r;
    assign cmd.do_read = act_r;
    assign cmd.index   = index_r;
    assign access_busy = state_r != ST_IDLE;

    // entry words: software writes when idle; a read loads them from the table.
    // a multicast read refreshes only word 2 and leaves the others as they were.
    genvar w;
    generate
        for (w = 0; w < `ENTRY_WORDS; w++)
        begin : g_entry
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                    entry_r[w] <= `ENTRY_RST;
                else if (state_r == ST_WAIT && store_done && act_r == `ACT_READ)
                begin
                    if (sel_r != `SEL_RMC || w == `RMC_WORD)
                        entry_r[w] <= store_rd[w];
                end
                else if (reg_wr && state_r == ST_IDLE && reg_addr == 16'(`OFF_ENTRY_1 + 4 * w))
                    entry_r[w] <= reg_wdata;
            end
        end
    endgenerate

    // the table store; entry words pass through untouched so their layout follows the table
    table_store #(
        .STATIC_DEPTH (STATIC_DEPTH),
        .RMC_DEPTH    (RMC_DEPTH)
    ) u_store (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .cmd_valid (cmd_valid),
        .cmd       (cmd),
        .wr_words  (entry_r),
        .rd_words  (store_rd),
        .rd_done   (store_done)
    );

    // control register as software sees it, reserved read-only bits zero
    assign ctrl_view = {10'h000, index_r, 8'h00, access_go_done_r, rsv_r, sel_r, act_r};

    // read mux; unmapped addresses answer zero
    always_comb
    begin
        case (reg_addr)
            `OFF_TBL_CTRL: rdata_nxt = ctrl_view;
            `OFF_ENTRY_1:  rdata_nxt = entry_r[0];
            `OFF_ENTRY_2:  rdata_nxt = entry_r[1];
            `OFF_ENTRY_3:  rdata_nxt = entry_r[2];
            `OFF_ENTRY_4:  rdata_nxt = entry_r[3];
            default:       rdata_nxt = `RDATA_UNMAPPED;
        endcase
    end

    // read data registered, valid one cycle after the strobe
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata  <= `RDATA_UNMAPPED;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rdata_nxt;
        end
    end

endmodule

// ===== tbl_access_properties.sv
// concurrent checks for the table access register block
// assumes it sees only the top module ports, one clock and async active-low reset
`timescale 1ns/1ps
`include "tbl_access_defs.svh"

module tbl_access_properties (
    input wire logic                   sys_clk,
    input wire logic                   resetn,
    input wire logic [`REG_ADDR_W-1:0] reg_addr,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_wdata,
    input wire logic [31:0]            reg_rdata,
    input wire logic                   reg_rvalid,
    input wire logic                   access_busy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // decoded strobes; a read paired with a write is left out as its answer is ambiguous
    wire logic ctl_rd  = reg_rd && !reg_wr && reg_addr == `OFF_TBL_CTRL;
    wire logic go_wr   = reg_wr && reg_addr == `OFF_TBL_CTRL && reg_wdata[`CTRL_GO_BIT];
    wire logic map_hit = reg_addr inside {`OFF_TBL_CTRL, `OFF_ENTRY_1, `OFF_ENTRY_2, `OFF_ENTRY_3, `OFF_ENTRY_4};

    property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_go_run; go_wr && !access_busy |=> access_busy [*2] ##1 !access_busy; endproperty
    a_go_run: assert property (p_go_run) else $error("access length wrong");
    property p_busy_cause; $rose(access_busy) |-> $past(go_wr); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
    property p_go_reads_1; ctl_rd && access_busy |=> reg_rdata[`CTRL_GO_BIT]; endproperty
    a_go_reads_1: assert property (p_go_reads_1) else $error("go low while running");
    property p_go_reads_0; ctl_rd && !access_busy |=> !reg_rdata[`CTRL_GO_BIT]; endproperty
    a_go_reads_0: assert property (p_go_reads_0) else $error("go high while idle");
    property p_ctl_rsv_zero; ctl_rd |=> reg_rdata[31:22] == 10'h000 && reg_rdata[15:8] == 8'h00; endproperty
    a_ctl_rsv_zero: assert property (p_ctl_rsv_zero) else $error("read-only bits set");
    property p_unmapped_zero; reg_rd && !map_hit |=> reg_rdata == `RDATA_UNMAPPED; endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    c_rmc_start: cover property (go_wr && reg_wdata[`CTRL_SEL_BIT]);
    c_static_start: cover property (go_wr && !reg_wdata[`CTRL_SEL_BIT]);
    c_done: cover property ($fell(access_busy));
endmodule

bind static_mcast_table_access tbl_access_properties u_props (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .access_busy(access_busy));

// ===== tb.sv
// self-checking bench for the table access register block
// assumes strobes taken on the rising edge, read data one cycle later
`timescale 1ns/1ps
`include "tbl_access_defs.svh"

module tb;
    import tbl_access_pkg::*;
    logic                   sys_clk;
    logic                   resetn;
    logic [`REG_ADDR_W-1:0] reg_addr;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [31:0]            reg_wdata;
    logic [31:0]            reg_rdata;
    logic                   reg_rvalid;
    logic                   access_busy;
    logic [31:0]            q;
    int                     bad_count;
    int                     checks;

    static_mcast_table_access DUT (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .access_busy(access_busy));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // each access waits an edge first, so a strobe is never dropped and raised in one step
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge sys_clk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #1 reg_rd = 1'b0;
        chk("read valid", 32'h1, {31'h0, reg_rvalid});
        q = reg_rdata;
    endtask

    task automatic fill(input entry_words_t w);
        for (int i = 0; i < 4; i++)
            wr(`OFF_ENTRY_1 + 16'(4 * i), w[i]);
    endtask

    task automatic expect_words(input entry_words_t w);
        for (int i = 0; i < 4; i++)
        begin
            rd(`OFF_ENTRY_1 + 16'(4 * i));
            chk("entry word", w[i], q);
        end
    endtask

    // start an access, time the busy span, then read the control word back
    task automatic acc(input logic [5:0] idx, input logic sel, input logic act);
        int n;
        logic [31:0] c;
        n = 0;
        c = {10'h000, idx, 8'h00, 1'b0, 5'h00, sel, act};
        wr(`OFF_TBL_CTRL, c | 32'h0000_0080);
        // software polls for done before touching anything again
        while (access_busy === 1'b1 && n < 8)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk("busy cycles", 32'd2, 32'(n));
        rd(`OFF_TBL_CTRL);
        chk("control after done", c, q);
    endtask

    initial
    begin
        resetn = 1'b0;
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0000_0000;
        bad_count = 0;
        checks = 0;
        repeat (5) @(posedge sys_clk);
        #1 resetn = 1'b1;
        expect_words('0);
        rd(`OFF_TBL_CTRL);
        chk("control reset", 32'h0, q);
        // static write with the upper index bits set, read back through the low four only
        fill({32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111});
        acc(6'h35, 1'b0, 1'b0);
        fill('0);
        acc(6'h05, 1'b0, 1'b1);
        expect_words({32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111});
        // multicast entries live in word two only; the other words keep their values
        fill({32'h0000_0004, 32'h0000_0003, 32'hA5A5_0002, 32'h0000_0001});
        acc(6'h35, 1'b1, 1'b0);
        fill({32'hC0C0_0004, 32'hC0C0_0003, 32'hC0C0_0002, 32'hC0C0_0001});
        acc(6'h35, 1'b1, 1'b1);
        expect_words({32'hC0C0_0004, 32'hC0C0_0003, 32'hA5A5_0002, 32'hC0C0_0001});
        acc(6'h05, 1'b1, 1'b1);
        expect_words({32'hC0C0_0004, 32'hC0C0_0003, 32'h0000_0000, 32'hC0C0_0001});
        acc(6'h15, 1'b0, 1'b1);
        expect_words({32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111});
        // go reads set mid-access, and an entry write landing mid-access is dropped
        wr(`OFF_TBL_CTRL, 32'h0009_0080);
        rd(`OFF_TBL_CTRL);
        chk("go while running", 32'h0009_0080, q);
        wr(`OFF_TBL_CTRL, 32'h0009_0080);
        wr(`OFF_ENTRY_1, 32'hDEAD_BEEF);
        rd(`OFF_ENTRY_1);
        chk("write while running", 32'h1111_1111, q);
        // a control write with go clear only updates the fields, no access follows
        wr(`OFF_TBL_CTRL, 32'h0003_007F);
        chk("busy after plain write", 32'h0, {31'h0, access_busy});
        rd(`OFF_TBL_CTRL);
        chk("control plain write", 32'h0003_007F, q);
        rd(16'h0430);
        chk("unmapped read", `RDATA_UNMAPPED, q);
        conclude();
    end

    // the whole sequence is about 130 cycles
    initial
    begin
        #40000;
        bad_count++;
        conclude();
    end
endmodule
